// *** hw/brc_core.sv ***
// brc_core: bcd clock/calendar, control, charger select and stop flag registers,
// with snapshot read buffers reached from a serial protocol engine on clk_link.
// assumes the engine waits for lnk_ready before each strobe and strobes one event at a time.
`timescale 1ns/1ps
module brc_core
  import brc_pkg::*;
#(
  parameter int OSC_STOP_CYC_P = OSC_STOP_CYC
) (
  input  wire logic       clk_sys,          // system clock, 100 MHz
  input  wire logic       rst_b,            // async reset, active low
  input  wire logic       osc_clk_in,       // 32.768 kHz oscillator pin
  input  wire logic       clk_link,         // protocol engine clock
  input  wire logic       lnk_start,        // bus start seen, pulse
  input  wire logic       lnk_stop,         // bus stop seen, pulse
  input  wire logic       lnk_ptr_load,     // word address received, pulse
  input  wire logic [3:0] lnk_ptr_val,      // new register pointer
  input  wire logic       lnk_byte_wr,      // data byte acknowledged, pulse
  input  wire logic [7:0] lnk_wdata,        // written byte
  input  wire logic       lnk_byte_rd,      // data byte sent to master, pulse
  output logic            lnk_ready,        // no event in flight
  output logic [7:0]      lnk_rdata,        // byte at current pointer
  output logic [3:0]      lnk_ptr,          // current register pointer
  output logic            test_level_pin,   // level or 512 Hz output
  output logic            charger_on,       // charger path enabled
  output logic            charger_diode,    // one series diode selected
  output logic [1:0]      charger_res       // resistor code, 0 when off
);

  // ---------------- link domain ----------------
  logic       req_tgl_r;
  logic       cmd_snap_r;
  logic       cmd_wr_r;
  logic [3:0] cmd_waddr_r;
  logic [7:0] cmd_wdata_r;
  logic [3:0] cmd_raddr_r;
  logic [3:0] ptr_r;
  logic       ack_s1_r;
  logic       ack_s2_r;
  logic       ack_s3_r;
  logic [7:0] lnk_rdata_r;
  logic       ack_tgl_r;
  logic [7:0] rdata_sys_r;

  function automatic logic [3:0] ptr_step(input logic [3:0] p);
    ptr_step = (p == ADR_CTRL || p >= ADR_FLAG) ? ADR_ZERO : p + 4'h1;
  endfunction

  wire       pending   = req_tgl_r ^ ack_s3_r;   // ready rises on the edge that loads lnk_rdata
  wire       any_evt   = lnk_start | lnk_stop | lnk_ptr_load | lnk_byte_wr | lnk_byte_rd;
  wire       issue     = any_evt & ~pending;
  wire       adv       = lnk_byte_wr | lnk_byte_rd;
  wire [3:0] ptr_adv   = ptr_step(ptr_r);
  wire [3:0] ptr_nxt   = lnk_ptr_load ? lnk_ptr_val : adv ? ptr_adv : ptr_r;
  // snapshot on start, stop, or an increment that lands on zero
  wire       snap_nxt  = lnk_start | lnk_stop | (adv & ptr_adv == ADR_ZERO);
  wire       ack_edge  = ack_s2_r ^ ack_s3_r;

  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      req_tgl_r   <= 1'b0;
      cmd_snap_r  <= 1'b0;
      cmd_wr_r    <= 1'b0;
      cmd_waddr_r <= ADR_ZERO;
      cmd_wdata_r <= ZERO8;
      cmd_raddr_r <= ADR_ZERO;
      ptr_r       <= ADR_ZERO;
    end else if (issue) begin
      req_tgl_r   <= ~req_tgl_r;
      cmd_snap_r  <= snap_nxt;
      cmd_wr_r    <= lnk_byte_wr;
      cmd_waddr_r <= ptr_r;
      cmd_wdata_r <= lnk_wdata;
      cmd_raddr_r <= ptr_nxt;
      ptr_r       <= ptr_nxt;
    end
  end

  // command fields stay frozen while pending, so only the toggle needs synchronising
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      ack_s1_r    <= 1'b0;
      ack_s2_r    <= 1'b0;
      ack_s3_r    <= 1'b0;
      lnk_rdata_r <= ZERO8;
    end else begin
      ack_s1_r    <= ack_tgl_r;
      ack_s2_r    <= ack_s1_r;
      ack_s3_r    <= ack_s2_r;
      if (ack_edge) begin
        lnk_rdata_r <= rdata_sys_r;
      end
    end
  end

  assign lnk_ready = ~pending;
  assign lnk_rdata = lnk_rdata_r;
  assign lnk_ptr   = ptr_r;

  // ---------------- system domain: crossing ----------------
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic reply_r;

  wire new_cmd = req_s2_r ^ req_s3_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      reply_r  <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      reply_r  <= new_cmd;
    end
  end

  // ---------------- registers ----------------
  logic [7:0]  sec_r;
  logic [7:0]  min_r;
  logic [7:0]  hr_r;
  logic [7:0]  day_r;
  logic [7:0]  date_r;
  logic [7:0]  mon_r;
  logic [7:0]  yr_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  chg_r;
  logic        osf_r;
  logic [7:0]  snap_r [0:6];

  wire       wr_hit  = new_cmd & cmd_wr_r;
  wire       wr_sec  = wr_hit & (cmd_waddr_r == ADR_SEC);
  wire       wr_min  = wr_hit & (cmd_waddr_r == ADR_MIN);
  wire       wr_hr   = wr_hit & (cmd_waddr_r == ADR_HR);
  wire       wr_day  = wr_hit & (cmd_waddr_r == ADR_DAY);
  wire       wr_date = wr_hit & (cmd_waddr_r == ADR_DATE);
  wire       wr_mon  = wr_hit & (cmd_waddr_r == ADR_MON);
  wire       wr_yr   = wr_hit & (cmd_waddr_r == ADR_YR);
  wire       wr_ctrl = wr_hit & (cmd_waddr_r == ADR_CTRL);
  wire       wr_chg  = wr_hit & (cmd_waddr_r == ADR_CHG);
  wire       wr_flag = wr_hit & (cmd_waddr_r == ADR_FLAG);
  wire       do_snap = new_cmd & cmd_snap_r;
  wire       div_clr = wr_sec | wr_ctrl;

  // ---------------- oscillator and divider ----------------
  logic        osc_s1_r;
  logic        osc_s2_r;
  logic        osc_s3_r;
  logic [14:0] div_r;
  logic [5:0]  cal_min_r;
  logic        cal_used_r;
  logic [7:0]  blank_r;
  logic [5:0]  ft_cnt_r;
  logic [15:0] wd_r;
  logic        run_r;

  wire osc_edge   = osc_s2_r & ~osc_s3_r;
  wire osc_en     = ~sec_r[SEC_OSC_DIS_BIT];
  wire cnt_tick   = osc_edge & osc_en;
  wire cal_pos    = ctrl_r[CTRL_SIGN_BIT];
  wire [5:0] cal_span = {ctrl_r[4:0], 1'b0};
  // one calibrated second per affected minute, limited to 62 of 64 minutes by the field width
  wire cal_win    = (cal_min_r < cal_span) & (sec_r[6:0] == CAL_SECOND) & ~cal_used_r;
  wire do_blank   = cnt_tick & cal_win & ~cal_pos;
  wire do_insert  = cnt_tick & cal_win & cal_pos & (div_r == DIV_INS_AT);
  wire sec_tick   = cnt_tick & ~do_blank & (div_r == DIV_TOP);
  wire [14:0] div_nxt = div_clr ? 15'h0000 :
                        do_blank ? div_r :
                        do_insert ? div_r + DIV_INS_STEP :
                        cnt_tick ? div_r + 15'h0001 : div_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      div_r    <= 15'h0000;
      ft_cnt_r <= 6'h00;
    end else begin
      osc_s1_r <= osc_clk_in;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      div_r    <= div_nxt;
      if (cnt_tick) begin
        ft_cnt_r <= ft_cnt_r + 6'h01;
      end
    end
  end

  // ---------------- bcd time chain ----------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] month_end(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mo[4:0] == 5'h02) begin
      month_end = leap ? BCD_29 : BCD_28;
    end else if (mo[4:0] == 5'h04 || mo[4:0] == 5'h06 || mo[4:0] == 5'h09 || mo[4:0] == 5'h11) begin
      month_end = BCD_30;
    end else begin
      month_end = BCD_31;
    end
  endfunction

  // no range checks: illogical entries just keep counting
  wire s_wrap = {1'b0, sec_r[6:0]} == BCD_59;
  wire m_wrap = {1'b0, min_r[6:0]} == BCD_59;
  wire h_wrap = {2'b00, hr_r[5:0]} == BCD_23;
  wire d_wrap = {2'b00, date_r[5:0]} == month_end(mon_r, yr_r);
  wire o_wrap = {3'b000, mon_r[4:0]} == BCD_12;
  wire y_wrap = yr_r == BCD_99;
  wire inc_m  = sec_tick & s_wrap;
  wire inc_h  = inc_m & m_wrap;
  wire inc_d  = inc_h & h_wrap;
  wire inc_o  = inc_d & d_wrap;
  wire inc_y  = inc_o & o_wrap;

  wire [7:0] sec_cnt  = s_wrap ? ZERO8 : bcd_inc({1'b0, sec_r[6:0]});
  wire [7:0] min_cnt  = m_wrap ? ZERO8 : bcd_inc({1'b0, min_r[6:0]});
  wire [7:0] hr_cnt   = h_wrap ? ZERO8 : bcd_inc({2'b00, hr_r[5:0]});
  wire [2:0] day_cnt  = (day_r[2:0] == DAY_LAST) ? DAY_FIRST : day_r[2:0] + 3'h1;
  wire [7:0] date_cnt = d_wrap ? BCD_01 : bcd_inc({2'b00, date_r[5:0]});
  wire [7:0] mon_cnt  = o_wrap ? BCD_01 : bcd_inc({3'b000, mon_r[4:0]});
  wire [7:0] yr_cnt   = y_wrap ? ZERO8 : bcd_inc(yr_r);
  wire       cflag_t  = inc_y & hr_r[HR_CEN_BIT];

  // a write wins over a tick on the same register
  wire [7:0] sec_nxt  = wr_sec  ? cmd_wdata_r : sec_tick ? {sec_r[7], sec_cnt[6:0]} : sec_r;
  wire [7:0] min_nxt  = wr_min  ? cmd_wdata_r : inc_m ? {min_r[7], min_cnt[6:0]} : min_r;
  wire [7:0] hr_nxt   = wr_hr   ? cmd_wdata_r :
                        {hr_r[7], hr_r[6] ^ cflag_t, inc_h ? hr_cnt[5:0] : hr_r[5:0]};
  wire [7:0] day_nxt  = wr_day  ? cmd_wdata_r : inc_d ? {day_r[7:3], day_cnt} : day_r;
  wire [7:0] date_nxt = wr_date ? cmd_wdata_r : inc_d ? {date_r[7:6], date_cnt[5:0]} : date_r;
  wire [7:0] mon_nxt  = wr_mon  ? cmd_wdata_r : inc_o ? {mon_r[7:5], mon_cnt[4:0]} : mon_r;
  wire [7:0] yr_nxt   = wr_yr   ? cmd_wdata_r : inc_y ? yr_cnt : yr_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sec_r  <= SEC_RST;
      min_r  <= MIN_RST;
      hr_r   <= HR_RST;
      day_r  <= DAY_RST;
      date_r <= DATE_RST;
      mon_r  <= MON_RST;
      yr_r   <= YR_RST;
      ctrl_r <= CTRL_RST;
      chg_r  <= CHG_RST;
    end else begin
      sec_r  <= sec_nxt;
      min_r  <= min_nxt;
      hr_r   <= hr_nxt;
      day_r  <= day_nxt;
      date_r <= date_nxt;
      mon_r  <= mon_nxt;
      yr_r   <= yr_nxt;
      if (wr_ctrl) begin
        ctrl_r <= cmd_wdata_r;
      end
      if (wr_chg) begin
        chg_r <= cmd_wdata_r;
      end
    end
  end

  // ---------------- calibration cycle ----------------
  // minute counter restarts with the divider so a control write lines the 64-minute cycle up
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cal_min_r  <= 6'h00;
      cal_used_r <= 1'b0;
      blank_r    <= 8'h00;
    end else if (div_clr) begin
      cal_min_r  <= 6'h00;
      cal_used_r <= 1'b0;
      blank_r    <= 8'h00;
    end else begin
      if (inc_m) begin
        cal_min_r  <= cal_min_r + 6'h01;
        cal_used_r <= 1'b0;
      end else if (do_insert || (do_blank && blank_r == CAL_BLANK_LAST)) begin
        cal_used_r <= 1'b1;
      end
      if (do_blank) begin
        blank_r <= (blank_r == CAL_BLANK_LAST) ? 8'h00 : blank_r + 8'h01;
      end
    end
  end

  // ---------------- oscillator stop flag ----------------
  // the watchdog notices a dead crystal; a disabled one sets the flag through osc_en, not the watchdog
  wire osc_alive = wd_r < 16'(OSC_STOP_CYC_P);
  wire run_now   = osc_alive & osc_en;
  wire osf_set   = run_r & ~run_now;
  wire osf_clr   = wr_flag & ~cmd_wdata_r[FLAG_OSF_BIT];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wd_r  <= 16'h0000;
      run_r <= 1'b0;
      osf_r <= 1'b1;
    end else begin
      wd_r  <= osc_edge ? 16'h0000 : (osc_alive ? wd_r + 16'h0001 : wd_r);
      run_r <= run_now;
      if (osf_set) begin
        osf_r <= 1'b1;
      end else if (osf_clr) begin
        osf_r <= 1'b0;
      end
    end
  end

  // ---------------- snapshot and read reply ----------------
  wire [7:0] live [0:6];
  assign live[0] = sec_r;
  assign live[1] = min_r;
  assign live[2] = hr_r;
  assign live[3] = day_r;
  assign live[4] = date_r;
  assign live[5] = mon_r;
  assign live[6] = yr_r;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_snap
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          snap_r[gi] <= ZERO8;
        end else if (do_snap) begin
          snap_r[gi] <= live[gi];
        end
      end
    end
  endgenerate

  wire [7:0] rd_mux = (cmd_raddr_r <= ADR_YR) ? snap_r[cmd_raddr_r[2:0]] :
                      (cmd_raddr_r == ADR_CTRL) ? ctrl_r :
                      (cmd_raddr_r == ADR_CHG) ? chg_r :
                      (cmd_raddr_r == ADR_FLAG) ? {osf_r, 7'h00} : ZERO8;

  // reply one cycle after the command so the read sees its own write and snapshot
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_tgl_r   <= 1'b0;
      rdata_sys_r <= ZERO8;
    end else if (reply_r) begin
      ack_tgl_r   <= ~ack_tgl_r;
      rdata_sys_r <= rd_mux;
    end
  end

  // ---------------- pins ----------------
  wire       chg_key  = chg_r[7:4] == CHG_KEY_ON;
  wire       diode_ok = (chg_r[3:2] == DIODE_NONE) | (chg_r[3:2] == DIODE_ONE);
  wire       res_ok   = chg_r[1:0] != RES_OFF;
  wire       chg_en   = chg_key & diode_ok & res_ok;
  // calibration never touches ft_cnt_r, so the test tone stays exact
  wire       pin_nxt  = ctrl_r[CTRL_FT_BIT] ? ft_cnt_r[FT_DIV_BIT] : ctrl_r[CTRL_OUT_BIT];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      test_level_pin <= 1'b1;
      charger_on     <= 1'b0;
      charger_diode  <= 1'b0;
      charger_res    <= 2'h0;
    end else begin
      test_level_pin <= pin_nxt;
      charger_on     <= chg_en;
      charger_diode  <= chg_en & (chg_r[3:2] == DIODE_ONE);
      charger_res    <= chg_en ? chg_r[1:0] : RES_OFF;
    end
  end

endmodule

// *** pkg/brc_pkg.sv ***
// brc_pkg: register map, field positions, reset values and timing for the bcd rtc core.
// assumes a 100 MHz system clock and a 32.768 kHz oscillator arriving on a pin.
package brc_pkg;

  // register pointer values (one byte each)
  localparam logic [3:0] ADR_SEC   = 4'h0;
  localparam logic [3:0] ADR_MIN   = 4'h1;
  localparam logic [3:0] ADR_HR    = 4'h2;
  localparam logic [3:0] ADR_DAY   = 4'h3;
  localparam logic [3:0] ADR_DATE  = 4'h4;
  localparam logic [3:0] ADR_MON   = 4'h5;
  localparam logic [3:0] ADR_YR    = 4'h6;
  localparam logic [3:0] ADR_CTRL  = 4'h7;
  localparam logic [3:0] ADR_CHG   = 4'h8;
  localparam logic [3:0] ADR_FLAG  = 4'h9;
  localparam logic [3:0] ADR_ZERO  = 4'h0;

  // field positions
  localparam int SEC_OSC_DIS_BIT = 7;
  localparam int HR_CEN_BIT      = 7;
  localparam int HR_CFLAG_BIT    = 6;
  localparam int CTRL_OUT_BIT    = 7;
  localparam int CTRL_FT_BIT     = 6;
  localparam int CTRL_SIGN_BIT   = 5;
  localparam int FLAG_OSF_BIT    = 7;
  localparam int FT_DIV_BIT      = 5;

  // reset values; time fields are undefined at power-up, these are just legal values
  localparam logic [7:0] SEC_RST  = 8'h00;
  localparam logic [7:0] MIN_RST  = 8'h00;
  localparam logic [7:0] HR_RST   = 8'h00;
  localparam logic [7:0] DAY_RST  = 8'h01;
  localparam logic [7:0] DATE_RST = 8'h01;
  localparam logic [7:0] MON_RST  = 8'h01;
  localparam logic [7:0] YR_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h80;
  localparam logic [7:0] CHG_RST  = 8'h00;
  localparam logic [7:0] ZERO8    = 8'h00;

  // bcd limits
  localparam logic [7:0] BCD_59   = 8'h59;
  localparam logic [7:0] BCD_23   = 8'h23;
  localparam logic [7:0] BCD_12   = 8'h12;
  localparam logic [7:0] BCD_99   = 8'h99;
  localparam logic [7:0] BCD_01   = 8'h01;
  localparam logic [7:0] BCD_28   = 8'h28;
  localparam logic [7:0] BCD_29   = 8'h29;
  localparam logic [7:0] BCD_30   = 8'h30;
  localparam logic [7:0] BCD_31   = 8'h31;
  localparam logic [2:0] DAY_LAST = 3'h7;
  localparam logic [2:0] DAY_FIRST = 3'h1;

  // charger select decode
  localparam logic [3:0] CHG_KEY_ON = 4'hA;
  localparam logic [1:0] DIODE_NONE = 2'h1;
  localparam logic [1:0] DIODE_ONE  = 2'h2;
  localparam logic [1:0] RES_OFF    = 2'h0;

  // divider chain: 15 bits, low byte is the divide-by-256 stage
  localparam logic [14:0] DIV_TOP      = 15'h7FFF;
  localparam logic [14:0] DIV_INS_AT   = 15'h00FF;
  localparam logic [14:0] DIV_INS_STEP = 15'h0101;
  localparam logic [7:0]  CAL_BLANK_LAST = 8'h7F;   // 128 blanked cycles
  localparam logic [6:0]  CAL_SECOND   = 7'h00;

  // oscillator stop detection time
  localparam int SYS_PERIOD_NS = 10;
  localparam int OSC_STOP_NS   = 100000;
  localparam int OSC_STOP_CYC  = OSC_STOP_NS / SYS_PERIOD_NS;

endpackage

// *** verification/brc_core_chk.sv ***
// brc_core_chk: port-level assertions for brc_core.
// assumes a bind to every brc_core; the link clock may stand still between events.
`timescale 1ns/1ps
module brc_core_chk
  import brc_pkg::*;
(
  input wire logic       clk_sys,      // system clock
  input wire logic       rst_b,        // async reset, active low
  input wire logic       clk_link,     // link clock
  input wire logic       lnk_start,    // start strobe
  input wire logic       lnk_stop,     // stop strobe
  input wire logic       lnk_ptr_load, // pointer load strobe
  input wire logic [3:0] lnk_ptr_val,  // new pointer
  input wire logic       lnk_byte_wr,  // write strobe
  input wire logic       lnk_byte_rd,  // read strobe
  input wire logic       lnk_ready,    // idle
  input wire logic [7:0] lnk_rdata,    // read byte
  input wire logic [3:0] lnk_ptr,      // pointer
  input wire logic       charger_on,   // charger enabled
  input wire logic [1:0] charger_res   // resistor code
);
  wire logic taken = lnk_ready && (lnk_start || lnk_stop || lnk_ptr_load || lnk_byte_wr || lnk_byte_rd);
  // a load in the same cycle owns the pointer, so it is kept out of the advance cases
  wire logic adv = lnk_ready && (lnk_byte_wr || lnk_byte_rd) && !lnk_ptr_load;

  busy_after_take_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    taken |=> !lnk_ready) else $error("ready stayed high after a strobe");
  busy_bound_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    $fell(lnk_ready) |-> ##[1:6] lnk_ready) else $error("event did not complete");
  wrap_seven_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    adv && lnk_ptr == ADR_CTRL |=> lnk_ptr == ADR_ZERO) else $error("pointer did not wrap after 7");
  wrap_nine_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    adv && lnk_ptr >= ADR_FLAG |=> lnk_ptr == ADR_ZERO) else $error("pointer did not wrap after 9");
  ptr_incr_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    adv && lnk_ptr != ADR_CTRL && lnk_ptr < ADR_FLAG |=> lnk_ptr == $past(lnk_ptr) + 4'h1)
    else $error("pointer did not advance by one");
  ptr_load_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    lnk_ready && lnk_ptr_load |=> lnk_ptr == $past(lnk_ptr_val)) else $error("pointer load lost");
  flag_low_zero_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    $rose(lnk_ready) && lnk_ptr == ADR_FLAG |-> lnk_rdata[6:0] == 7'h00) else $error("flag low bits set");
  unmapped_zero_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    $rose(lnk_ready) && lnk_ptr > ADR_FLAG |-> lnk_rdata == ZERO8) else $error("unmapped read not zero");
  busy_hold_a: assert property (@(posedge clk_link) disable iff (!rst_b)
    !lnk_ready ##1 !lnk_ready |-> $stable(lnk_rdata) && $stable(lnk_ptr)) else $error("outputs moved while busy");
  chg_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !charger_on |-> charger_res == RES_OFF) else $error("resistor code while off");
  chg_res_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    charger_on |-> charger_res != RES_OFF) else $error("charger on with no resistor");

  wrap_c: cover property (@(posedge clk_link) disable iff (!rst_b) adv && lnk_ptr == ADR_CTRL);
  chg_c: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(charger_on));
  unmap_c: cover property (@(posedge clk_link) disable iff (!rst_b) $rose(lnk_ready) && lnk_ptr > ADR_FLAG);
endmodule

bind brc_core brc_core_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .clk_link(clk_link),
  .lnk_start(lnk_start), .lnk_stop(lnk_stop), .lnk_ptr_load(lnk_ptr_load), .lnk_ptr_val(lnk_ptr_val),
  .lnk_byte_wr(lnk_byte_wr), .lnk_byte_rd(lnk_byte_rd), .lnk_ready(lnk_ready), .lnk_rdata(lnk_rdata),
  .lnk_ptr(lnk_ptr), .charger_on(charger_on), .charger_res(charger_res));

// *** verification/brc_host_model.sv ***
// brc_host_model: protocol engine side, one event per call, link clock runs only in events.
// assumes the testbench calls ev and pulse; released data lines show the inverse value.
`timescale 1ns/1ps
module brc_host_model (
  output logic       clk_link,     // link clock, 160 ns
  output logic       lnk_start,    // start strobe
  output logic       lnk_stop,     // stop strobe
  output logic       lnk_ptr_load, // pointer load strobe
  output logic [3:0] lnk_ptr_val,  // new pointer
  output logic       lnk_byte_wr,  // write strobe
  output logic [7:0] lnk_wdata,    // write byte
  output logic       lnk_byte_rd,  // read strobe
  input  wire logic  lnk_ready,    // idle
  input  wire logic [7:0] lnk_rdata // read byte
);
  logic [7:0] rd_r;
  logic       ok_r;

  initial begin
    clk_link = 1'b0;
    {lnk_start, lnk_stop, lnk_ptr_load, lnk_byte_wr, lnk_byte_rd} = 5'h00;
    lnk_ptr_val = 4'hF;
    lnk_wdata = 8'hFF;
  end

  task automatic pulse(input int n);
    repeat (n) begin
      #80 clk_link = 1'b1;
      #80 clk_link = 1'b0;
    end
  endtask

  // k = {start, stop, load, write, read}; one strobe per event
  task automatic ev(input logic [4:0] k, input logic [3:0] p, input logic [7:0] d);
    {lnk_start, lnk_stop, lnk_ptr_load, lnk_byte_wr, lnk_byte_rd} = k;
    lnk_ptr_val = p;
    lnk_wdata = d;
    pulse(1);
    {lnk_start, lnk_stop, lnk_ptr_load, lnk_byte_wr, lnk_byte_rd} = 5'h00;
    lnk_ptr_val = ~p;
    lnk_wdata = ~d;
    ok_r = 1'b0;
    // ready and data are sampled just before each rising edge
    for (int n = 0; n < 8 && !ok_r; n++) begin
      #79 ok_r = (lnk_ready === 1'b1);
      rd_r = lnk_rdata;
      #1 clk_link = 1'b1;
      #80 clk_link = 1'b0;
    end
  endtask
endmodule

// *** verification/brc_core_test.sv ***
// brc_core_test: register, charger, pin, flag and pointer scenarios for brc_core.
// assumes brc_host_model drives the link; oscillator sped up to a 200 ns period.
`timescale 1ns/1ps
module brc_core_test;
  import brc_pkg::*;
  logic            clk_sys, rst_b, osc_clk_in, osc_hold;
  wire logic       clk_link, lnk_start, lnk_stop, lnk_ptr_load, lnk_byte_wr, lnk_byte_rd, lnk_ready;
  wire logic [3:0] lnk_ptr_val, lnk_ptr;
  wire logic [7:0] lnk_wdata, lnk_rdata;
  wire logic       test_level_pin, charger_on, charger_diode;
  wire logic [1:0] charger_res;
  int              err_count, checks, n;

  brc_core #(.OSC_STOP_CYC_P(400)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .osc_clk_in(osc_clk_in),
    .clk_link(clk_link), .lnk_start(lnk_start), .lnk_stop(lnk_stop), .lnk_ptr_load(lnk_ptr_load),
    .lnk_ptr_val(lnk_ptr_val), .lnk_byte_wr(lnk_byte_wr), .lnk_wdata(lnk_wdata), .lnk_byte_rd(lnk_byte_rd),
    .lnk_ready(lnk_ready), .lnk_rdata(lnk_rdata), .lnk_ptr(lnk_ptr), .test_level_pin(test_level_pin),
    .charger_on(charger_on), .charger_diode(charger_diode), .charger_res(charger_res));
  brc_host_model u_host (.clk_link(clk_link), .lnk_start(lnk_start), .lnk_stop(lnk_stop),
    .lnk_ptr_load(lnk_ptr_load), .lnk_ptr_val(lnk_ptr_val), .lnk_byte_wr(lnk_byte_wr), .lnk_wdata(lnk_wdata),
    .lnk_byte_rd(lnk_byte_rd), .lnk_ready(lnk_ready), .lnk_rdata(lnk_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    osc_clk_in = 1'b0;
    forever #100 if (!osc_hold) osc_clk_in = ~osc_clk_in;
  end

  task automatic finish_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ev(input logic [4:0] k, input logic [3:0] p, input logic [7:0] d);
    u_host.ev(k, p, d);
    chk({7'h00, u_host.ok_r}, 8'h01);
    if (u_host.ok_r !== 1'b1) finish_test();
  endtask
  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    ev(5'h04, p, 8'h00);
    ev(5'h02, 4'h0, d);
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] p, input logic [7:0] e);
    ev(5'h04, p, 8'h00);
    chk(u_host.rd_r, e);
  endtask
  task automatic gap(output int c);
    logic p;
    p = test_level_pin;
    for (c = 0; c < 1000 && test_level_pin === p; c++) @(negedge clk_sys);
    if (c >= 1000) begin
      chk(8'h00, 8'h01);
      finish_test();
    end
  endtask

  task automatic t_reset;
    chk({7'h00, test_level_pin}, 8'h01);
    chk({5'h00, charger_on, charger_res}, 8'h00);
    rd(ADR_CTRL, CTRL_RST);
    rd(ADR_CHG, CHG_RST);
    rd(ADR_FLAG, 8'h80);
    rd(ADR_SEC, SEC_RST);
    $display("test reset done");
  endtask
  task automatic t_charger;
    logic [7:0] v [8] = '{8'hA5, 8'hAA, 8'hA7, 8'hAB, 8'hA1, 8'hAD, 8'hA4, 8'h55};
    logic [3:0] e [8] = '{4'h9, 4'hE, 4'hB, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0};
    for (int i = 0; i < 8; i++) begin
      wr(ADR_CHG, v[i]);
      chk({4'h0, charger_on, charger_diode, charger_res}, {4'h0, e[i]});
      rd(ADR_CHG, v[i]);
    end
    $display("test charger done");
  endtask
  task automatic t_ctrl;
    wr(ADR_CTRL, 8'h00);
    chk({7'h00, test_level_pin}, 8'h00);
    wr(ADR_CTRL, 8'h3F);
    rd(ADR_CTRL, 8'h3F);
    // calibration set to full scale must not move the test square
    wr(ADR_CTRL, 8'h7F);
    gap(n);
    gap(n);
    chk({7'h00, n >= 620 && n <= 660}, 8'h01);
    wr(ADR_CTRL, 8'h80);
    chk({7'h00, test_level_pin}, 8'h01);
    $display("test control done");
  endtask
  task automatic t_flag;
    wr(ADR_FLAG, 8'hFF);
    rd(ADR_FLAG, 8'h80);
    wr(ADR_FLAG, 8'h7F);
    rd(ADR_FLAG, 8'h00);
    wr(ADR_SEC, 8'h80);
    repeat (50) @(negedge clk_sys);
    rd(ADR_FLAG, 8'h80);
    wr(ADR_SEC, 8'h00);
    wr(ADR_FLAG, 8'h00);
    rd(ADR_FLAG, 8'h00);
    osc_hold = 1'b1;
    repeat (600) @(negedge clk_sys);
    rd(ADR_FLAG, 8'h80);
    osc_hold = 1'b0;
    $display("test flag done");
  endtask
  task automatic t_ptr;
    wr(ADR_MIN, 8'h12);
    ev(5'h10, 4'h0, 8'h00);
    rd(ADR_MIN, 8'h12);
    wr(ADR_MIN, 8'h34);
    rd(ADR_MIN, 8'h12);
    ev(5'h04, ADR_YR, 8'h00);
    ev(5'h01, 4'h0, 8'h00);
    chk({4'h0, lnk_ptr}, 8'h07);
    ev(5'h01, 4'h0, 8'h00);
    chk({4'h0, lnk_ptr}, 8'h00);
    rd(ADR_MIN, 8'h34);
    ev(5'h04, ADR_FLAG, 8'h00);
    ev(5'h01, 4'h0, 8'h00);
    chk({4'h0, lnk_ptr}, 8'h00);
    wr(4'hC, 8'h5A);
    rd(4'hC, 8'h00);
    $display("test pointer done");
  endtask

  initial begin
    rst_b = 1'b0;
    osc_hold = 1'b0;
    err_count = 0;
    checks = 0;
    // two link edges are needed inside reset, so it outlasts eight system cycles
    fork
      repeat (8) @(negedge clk_sys);
      u_host.pulse(2);
    join
    @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_charger();
    t_ctrl();
    t_flag();
    t_ptr();
    finish_test();
  end
endmodule
